/* File: hvsp_pkg.sv */
// constants, codes and helpers shared by both ends of the programming port
package hvsp_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int FRAME_BITS = 11;
  localparam logic [3:0] FRAME_LAST = 4'hA;
  // incoming byte sits in frame bits 9..2, outgoing byte in bits 10..3
  localparam int IN_MSB = 9;
  localparam int IN_LSB = 2;
  localparam int OUT_MSB = 10;
  localparam int OUT_LSB = 3;
  // strap_latch_hold_time and the wait before the first frame
  localparam int STRAP_HOLD_NS = 10_000;
  localparam int STRAP_HOLD_CYC = (STRAP_HOLD_NS * CYC_PER_US + 999) / 1000;
  localparam int STRAP_SAMPLE_CYC = STRAP_HOLD_CYC / 2;
  localparam int ENTRY_WAIT_NS = 1_300_000;
  localparam int ENTRY_WAIT_CYC = (ENTRY_WAIT_NS * CYC_PER_US + 999) / 1000;
  localparam int VCC_SETTLE_NS = 40_000;
  localparam int VCC_SETTLE_CYC = (VCC_SETTLE_NS * CYC_PER_US + 999) / 1000;
  localparam int SCK_HALF_CYC = 4;
  localparam int GAP_CYC = 2 * SCK_HALF_CYC;
  // strap lines: index of each serial signal on the shared pins
  localparam logic [3:0] ENTRY_PATTERN = 4'h0;
  localparam int LINE_SDO = 1;
  localparam int LINE_SDI = 2;
  localparam int LINE_SII = 3;
  localparam logic [3:0] OE_ENTRY = 4'hF;
  localparam logic [3:0] OE_RUN = 4'hD;
  // instruction bytes on serial_instruction_in
  localparam logic [7:0] I_LOAD_CMD = 8'h4C;
  localparam logic [7:0] I_ADDR_LO = 8'h0C;
  localparam logic [7:0] I_ADDR_HI = 8'h1C;
  localparam logic [7:0] I_DATA_LO = 8'h2C;
  localparam logic [7:0] I_DATA_HI = 8'h3C;
  localparam logic [7:0] I_LATCH_F = 8'h7D;
  localparam logic [7:0] I_LATCH_E = 8'h6D;
  localparam logic [7:0] I_PROG_A = 8'h64;
  localparam logic [7:0] I_PROG_B = 8'h6C;
  localparam logic [7:0] I_RD_LO = 8'h68;
  localparam logic [7:0] I_RD_HI = 8'h78;
  // command bytes on serial_data_in with I_LOAD_CMD
  localparam logic [7:0] C_NOP = 8'h00;
  localparam logic [7:0] C_ERASE = 8'h80;
  localparam logic [7:0] C_WR_FLASH = 8'h10;
  localparam logic [7:0] C_RD_FLASH = 8'h02;
  localparam logic [7:0] C_WR_EE = 8'h11;
  localparam logic [7:0] C_RD_EE = 8'h03;
  // storage
  localparam int MEM_AW = 9;
  localparam int MEM_WORDS = 512;
  localparam int FPAGE_AW = 3;
  localparam int EPAGE_AW = 2;
  localparam int PAGE_WORDS = 8;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam int LOCK_W = 2;
  localparam logic [1:0] LOCK_CLEAR = 2'h3;

  function automatic logic [7:0] hvsp_in_byte(input logic [FRAME_BITS-1:0] f);
    return f[IN_MSB:IN_LSB];
  endfunction : hvsp_in_byte

  function automatic logic [FRAME_BITS-1:0] hvsp_in_frame(input logic [7:0] b);
    return {1'b0, b, 2'b00};
  endfunction : hvsp_in_frame

  function automatic logic [FRAME_BITS-1:0] hvsp_out_frame(input logic [7:0] b);
    return {b, 3'b000};
  endfunction : hvsp_out_frame
endpackage : hvsp_pkg

/* File: hvsp_if.sv */
// pins between programmer and device, resolved to wire levels
`timescale 1ns/1ps
interface hvsp_if;
  logic hv_rst;
  logic vcc_on;
  logic serial_clock_in;
  logic [3:0] host_pin;
  logic [3:0] host_oe;
  logic dev_sdo;
  logic dev_sdo_oe;
  logic [3:0] line;
  logic contention;

  // undriven lines float high through the port pull-ups
  assign line[0] = host_oe[0] ? host_pin[0] : 1'b1;
  assign line[1] = host_oe[1] ? host_pin[1] : (dev_sdo_oe ? dev_sdo : 1'b1);
  assign line[2] = host_oe[2] ? host_pin[2] : 1'b1;
  assign line[3] = host_oe[3] ? host_pin[3] : 1'b1;
  assign contention = host_oe[1] & dev_sdo_oe;

  modport host (output hv_rst, vcc_on, serial_clock_in, host_pin, host_oe, input line);
  modport dev (input hv_rst, vcc_on, serial_clock_in, line, output dev_sdo, dev_sdo_oe);
endinterface : hvsp_if

/* File: hvsp_frame.sv */
// eleven-bit serial frame shifter, two lanes each way
`timescale 1ns/1ps
module hvsp_frame (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // control
  input wire logic clear_i,
  input wire logic sample_i,
  input wire logic shift_i,
  input wire logic load_i,
  // serial side
  input wire logic [1:0] rx_i,
  output logic [1:0] tx_o,
  // parallel side
  input wire logic [1:0][hvsp_pkg::FRAME_BITS-1:0] tx_i,
  output logic [1:0][hvsp_pkg::FRAME_BITS-1:0] rx_o,
  output logic done_o,
  output logic active_o
);
  import hvsp_pkg::*;

  logic [3:0] cnt_r;
  logic done_r;
  logic [1:0][FRAME_BITS-1:0] tx_r;
  logic [1:0][FRAME_BITS-1:0] rx_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 4'h0;
      done_r <= 1'b0;
    end else if (ce_i) begin
      done_r <= sample_i && !clear_i && (cnt_r == FRAME_LAST);
      if (clear_i) begin
        cnt_r <= 4'h0;
      end else if (sample_i) begin
        cnt_r <= (cnt_r == FRAME_LAST) ? 4'h0 : cnt_r + 4'h1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          tx_r[g] <= '0;
          rx_r[g] <= '0;
        end else if (ce_i) begin
          if (load_i) begin
            tx_r[g] <= tx_i[g];
          end else if (shift_i) begin
            tx_r[g] <= {tx_r[g][FRAME_BITS-2:0], 1'b0};
          end
          if (sample_i) begin
            rx_r[g] <= {rx_r[g][FRAME_BITS-2:0], rx_i[g]};
          end
        end
      end
      assign tx_o[g] = tx_r[g][FRAME_BITS-1];
    end
  endgenerate

  assign rx_o = rx_r;
  assign done_o = done_r;
  assign active_o = (cnt_r != 4'h0);
endmodule : hvsp_frame

/* File: hvsp_dev.sv */
// device end: mode entry, frame decode, page buffer and memory arrays
// Functional notes
// - four lines: data out, data in, instruction, clock
// - programmer holds straps 0000 while raising high voltage
// - straps held 10 us; device latches inside that
// - programmer releases the data-out strap after latching
// - programmer waits 1.3 ms before the first frame
// - command and address kept across operations
// - high address byte kept until reloaded
// - erased locations read back as all ones
// - erase clears flash, eeprom, lock; fuses untouched
// - lock bits cleared only after flash fully erased
// - preserve fuse keeps eeprom through erase
// - programmer erases before reprogramming
// - erase done shown by data out going high
// - flash page sequence, wait for ready per page
// - flash data buffered, whole page written at once
// - data and instruction bits taken on clock rise
// - eeprom page sequence, wait for ready per page
// - read flash shifts low then high byte out
// - read eeprom shifts the selected byte out
// - mode left on power down or reset low
`timescale 1ns/1ps
module hvsp_dev (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // programming pins
  hvsp_if.dev pins,
  // device side
  input wire logic preserve_eeprom_fuse_i,
  output logic prog_mode_o,
  output logic busy_o,
  output logic [hvsp_pkg::LOCK_W-1:0] lock_bits_o
);
  import hvsp_pkg::*;

  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_LATCH = 7'h02,
    ST_REJ = 7'h04,
    ST_IDLE = 7'h08,
    ST_ERASE = 7'h10,
    ST_LOCK = 7'h20,
    ST_PROG = 7'h40
  } hvsp_dev_e;

  hvsp_dev_e st_r;
  hvsp_dev_e st_nxt;
  logic [6:0] sy1_r;
  logic [6:0] sy2_r;
  logic sci_d_r;
  logic hv_d_r;
  logic [7:0] cnt_r;
  logic [MEM_AW-1:0] idx_r;
  logic [7:0] cmd_r;
  logic [7:0] alo_r;
  logic [7:0] ahi_r;
  logic [7:0] dlo_r;
  logic [7:0] dhi_r;
  logic [7:0] prev_r;
  logic out_sel_r;
  logic sdo_r;
  logic [LOCK_W-1:0] lock_r;
  logic [15:0] pbuf_r [PAGE_WORDS];
  logic [15:0] flash_r [MEM_WORDS];
  logic [7:0] ee_r [MEM_WORDS];
  logic sci_s;
  logic hv_s;
  logic vcc_s;
  logic [3:0] line_s;
  logic rise;
  logic in_mode;
  logic busy;
  logic fdone;
  logic fidle;
  logic go;
  logic rd_load;
  logic [7:0] rd_byte;
  logic [7:0] fin_d;
  logic [7:0] fin_i;
  logic [MEM_AW-1:0] fa;
  logic [MEM_AW-1:0] fpg;
  logic [MEM_AW-1:0] epg;
  logic [1:0] tx_bits;
  logic [1:0][FRAME_BITS-1:0] rx_fr;
  logic [1:0][FRAME_BITS-1:0] tx_fr;

  // every pin is asynchronous to clk_i, so two flops before use
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sy1_r <= 7'h00;
      sy2_r <= 7'h00;
      sci_d_r <= 1'b0;
      hv_d_r <= 1'b0;
    end else if (ce_i) begin
      sy1_r <= {pins.serial_clock_in, pins.hv_rst, pins.vcc_on, pins.line};
      sy2_r <= sy1_r;
      sci_d_r <= sci_s;
      hv_d_r <= hv_s;
    end
  end

  assign {sci_s, hv_s, vcc_s, line_s} = sy2_r;
  assign rise = sci_s & ~sci_d_r;
  assign in_mode = (st_r == ST_IDLE) || busy;
  assign busy = (st_r == ST_ERASE) || (st_r == ST_LOCK) || (st_r == ST_PROG);
  assign fidle = fdone && (st_r == ST_IDLE);
  assign fin_d = hvsp_in_byte(rx_fr[0]);
  assign fin_i = hvsp_in_byte(rx_fr[1]);
  assign fa = {ahi_r[0], alo_r};
  assign fpg = {fa[MEM_AW-1:FPAGE_AW], idx_r[FPAGE_AW-1:0]};
  assign epg = {fa[MEM_AW-1:EPAGE_AW], idx_r[EPAGE_AW-1:0]};
  assign go = fidle && (fin_i == I_PROG_B) && (prev_r == I_PROG_A);
  assign rd_load = fidle && (((fin_i == I_RD_LO) && ((cmd_r == C_RD_FLASH) ||
                   (cmd_r == C_RD_EE))) || ((fin_i == I_RD_HI) && (cmd_r == C_RD_FLASH)));

  always_comb begin
    rd_byte = ee_r[fa];
    if (cmd_r == C_RD_FLASH) begin
      rd_byte = (fin_i == I_RD_HI) ? flash_r[fa][15:8] : flash_r[fa][7:0];
    end
  end

  assign tx_fr[0] = hvsp_out_frame(rd_byte);
  assign tx_fr[1] = '0;

  hvsp_frame u_frame (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_i(!in_mode),
    .sample_i(rise && in_mode),
    .shift_i(rise && in_mode && out_sel_r),
    .load_i(rd_load),
    .rx_i({line_s[LINE_SII], line_s[LINE_SDI]}),
    .tx_o(tx_bits),
    .tx_i(tx_fr),
    .rx_o(rx_fr),
    .done_o(fdone),
    .active_o()
  );

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_OFF: if (hv_s && !hv_d_r) st_nxt = ST_LATCH;
      ST_LATCH: begin
        if (cnt_r == 8'(STRAP_SAMPLE_CYC - 1)) begin
          st_nxt = (line_s == ENTRY_PATTERN) ? ST_IDLE : ST_REJ;
        end
      end
      ST_REJ: st_nxt = ST_REJ;
      ST_IDLE: begin
        if (go && (cmd_r == C_ERASE)) begin
          st_nxt = ST_ERASE;
        end else if (go && ((cmd_r == C_WR_FLASH) || (cmd_r == C_WR_EE))) begin
          st_nxt = ST_PROG;
        end
      end
      ST_ERASE: if (idx_r == MEM_AW'(MEM_WORDS - 1)) st_nxt = ST_LOCK;
      ST_LOCK: st_nxt = ST_IDLE;
      ST_PROG: if (idx_r == MEM_AW'(PAGE_WORDS - 1)) st_nxt = ST_IDLE;
      default: st_nxt = ST_OFF;
    endcase
    if (!vcc_s || !hv_s) begin
      st_nxt = ST_OFF;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= ST_OFF;
      cnt_r <= 8'h00;
      idx_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
      cnt_r <= (st_r == ST_LATCH) ? cnt_r + 8'h01 : 8'h00;
      idx_r <= ((st_r == st_nxt) && (busy && st_r != ST_LOCK)) ? idx_r + 1'b1 : '0;
    end
  end

  // command and address survive every operation until reloaded
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_r <= C_NOP;
      alo_r <= 8'h00;
      ahi_r <= 8'h00;
      dlo_r <= ERASED_BYTE;
      dhi_r <= ERASED_BYTE;
      prev_r <= 8'h00;
    end else if (ce_i) begin
      if (fidle) begin
        prev_r <= fin_i;
        case (fin_i)
          I_LOAD_CMD: cmd_r <= fin_d;
          I_ADDR_LO: alo_r <= fin_d;
          I_ADDR_HI: ahi_r <= fin_d;
          I_DATA_LO: dlo_r <= fin_d;
          I_DATA_HI: dhi_r <= fin_d;
          default: prev_r <= fin_i;
        endcase
      end
      if (st_r == ST_OFF) begin
        prev_r <= 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_sel_r <= 1'b0;
      sdo_r <= 1'b1;
      lock_r <= LOCK_CLEAR;
    end else if (ce_i) begin
      if (rd_load) begin
        out_sel_r <= 1'b1;
      end else if (fdone || !in_mode) begin
        out_sel_r <= 1'b0;
      end
      sdo_r <= out_sel_r ? tx_bits[0] : !busy;
      if (st_r == ST_LOCK) begin
        lock_r <= LOCK_CLEAR;
      end
    end
  end

  // arrays have no reset so they synthesise as plain storage
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (fidle && (fin_i == I_LATCH_F) && (cmd_r == C_WR_FLASH)) begin
        pbuf_r[alo_r[FPAGE_AW-1:0]] <= {dhi_r, dlo_r};
      end
      if (fidle && (fin_i == I_LATCH_E) && (cmd_r == C_WR_EE)) begin
        pbuf_r[FPAGE_AW'(alo_r[EPAGE_AW-1:0])] <= {ERASED_BYTE, dlo_r};
      end
      if (st_r == ST_ERASE) begin
        flash_r[idx_r] <= ERASED_WORD;
        pbuf_r[idx_r[FPAGE_AW-1:0]] <= ERASED_WORD;
        if (!preserve_eeprom_fuse_i) begin
          ee_r[idx_r] <= ERASED_BYTE;
        end
      end
      if ((st_r == ST_PROG) && (cmd_r == C_WR_FLASH)) begin
        flash_r[fpg] <= pbuf_r[idx_r[FPAGE_AW-1:0]];
      end
      if ((st_r == ST_PROG) && (cmd_r == C_WR_EE) && (idx_r < MEM_AW'(4))) begin
        ee_r[epg] <= pbuf_r[idx_r[FPAGE_AW-1:0]][7:0];
      end
      // unloaded words must program as erased, so refill after use
      if (st_r == ST_PROG) begin
        pbuf_r[idx_r[FPAGE_AW-1:0]] <= ERASED_WORD;
      end
    end
  end

  // the fuse is only ever read in the erase branch above, erase never writes it
  assign pins.dev_sdo = sdo_r;
  assign pins.dev_sdo_oe = in_mode;
  assign prog_mode_o = in_mode;
  assign busy_o = busy;
  assign lock_bits_o = lock_r;
endmodule : hvsp_dev

/* File: hvsp_host.sv */
// programmer end: power and strap sequence, clock divider, frame issue
`timescale 1ns/1ps
module hvsp_host #(
  parameter int ENTRY_WAIT = hvsp_pkg::ENTRY_WAIT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // programming pins
  hvsp_if.host pins,
  // mode control
  input wire logic enter_i,
  input wire logic exit_i,
  // frame request
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [7:0] cmd_instr_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic cmd_wait_i,
  // frame answer
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o
);
  import hvsp_pkg::*;

  typedef enum logic [7:0] {
    H_OFF = 8'h01,
    H_PWR = 8'h02,
    H_HV = 8'h04,
    H_SETTLE = 8'h08,
    H_IDLE = 8'h10,
    H_SEND = 8'h20,
    H_GAP = 8'h40,
    H_WAIT = 8'h80
  } hvsp_host_e;

  hvsp_host_e st_r;
  logic [15:0] cnt_r;
  logic [2:0] ph_r;
  logic sck_r;
  logic wait_r;
  logic [1:0] sdo_sy_r;
  logic rsp_v_r;
  logic [7:0] rsp_r;
  logic tog;
  logic fdone;
  logic factive;
  logic take;
  logic [1:0] tx_bits;
  logic [1:0][FRAME_BITS-1:0] rx_fr;
  logic [1:0][FRAME_BITS-1:0] tx_fr;

  assign take = (st_r == H_IDLE) && cmd_valid_i;
  assign tog = (st_r == H_SEND) && (ph_r == 3'(SCK_HALF_CYC - 1));
  assign tx_fr[0] = hvsp_in_frame(cmd_data_i);
  assign tx_fr[1] = hvsp_in_frame(cmd_instr_i);

  // data changes on the fall so it is stable at the device's rise
  hvsp_frame u_frame (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_i(st_r != H_SEND),
    .sample_i(tog && !sck_r),
    .shift_i(tog && sck_r),
    .load_i(take),
    .rx_i({1'b0, sdo_sy_r[1]}),
    .tx_o(tx_bits),
    .tx_i(tx_fr),
    .rx_o(rx_fr),
    .done_o(fdone),
    .active_o(factive)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sdo_sy_r <= 2'b00;
      ph_r <= 3'h0;
      sck_r <= 1'b0;
    end else if (ce_i) begin
      sdo_sy_r <= {sdo_sy_r[0], pins.line[LINE_SDO]};
      ph_r <= (tog || st_r != H_SEND) ? 3'h0 : ph_r + 3'h1;
      sck_r <= (st_r == H_SEND) ? (sck_r ^ tog) : 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= H_OFF;
      cnt_r <= 16'h0000;
      wait_r <= 1'b0;
      rsp_v_r <= 1'b0;
      rsp_r <= 8'h00;
    end else if (ce_i) begin
      cnt_r <= cnt_r + 16'h0001;
      rsp_v_r <= 1'b0;
      case (st_r)
        H_OFF: begin
          cnt_r <= 16'h0000;
          if (enter_i) st_r <= H_PWR;
        end
        H_PWR: begin
          if (cnt_r == 16'(VCC_SETTLE_CYC - 1)) begin
            st_r <= H_HV;
            cnt_r <= 16'h0000;
          end
        end
        H_HV: begin
          if (cnt_r == 16'(STRAP_HOLD_CYC)) begin
            st_r <= H_SETTLE;
            cnt_r <= 16'h0000;
          end
        end
        H_SETTLE: if (cnt_r == 16'(ENTRY_WAIT - 1)) st_r <= H_IDLE;
        H_IDLE: begin
          cnt_r <= 16'h0000;
          if (take) begin
            st_r <= H_SEND;
            wait_r <= cmd_wait_i;
          end
        end
        H_SEND: begin
          cnt_r <= 16'h0000;
          if (fdone) begin
            rsp_r <= rx_fr[0][OUT_MSB:OUT_LSB];
          end
          // leave on the last fall so the final clock pulse is full length
          if (tog && sck_r && !factive) begin
            st_r <= H_GAP;
          end
        end
        H_GAP: begin
          if (cnt_r == 16'(GAP_CYC - 1)) begin
            st_r <= wait_r ? H_WAIT : H_IDLE;
            rsp_v_r <= !wait_r;
          end
        end
        H_WAIT: begin
          if (sdo_sy_r[1]) begin
            st_r <= H_IDLE;
            rsp_v_r <= 1'b1;
          end
        end
        default: st_r <= H_OFF;
      endcase
      if (exit_i) begin
        st_r <= H_OFF;
      end
    end
  end

  // straps driven low through entry; the data-out strap is let go after
  always_comb begin
    pins.host_oe = 4'h0;
    if ((st_r == H_PWR) || (st_r == H_HV)) begin
      pins.host_oe = OE_ENTRY;
    end else if (st_r != H_OFF) begin
      pins.host_oe = OE_RUN;
    end
  end

  assign pins.host_pin = {tx_bits[1], tx_bits[0], 2'b00};
  assign pins.vcc_on = (st_r != H_OFF);
  assign pins.hv_rst = (st_r != H_OFF) && (st_r != H_PWR);
  assign pins.serial_clock_in = sck_r;
  assign cmd_ready_o = (st_r == H_IDLE);
  assign rsp_valid_o = rsp_v_r;
  assign rsp_data_o = rsp_r;
endmodule : hvsp_host

/* File: hvsp_chk.sv */
// pin-level checks between the host and device ends of the programming port
`timescale 1ns/1ps
module hvsp_chk
  import hvsp_pkg::*;
#(
  parameter int ENTRY_WAIT = ENTRY_WAIT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pins
  input wire logic hv_rst,
  input wire logic vcc_on,
  input wire logic serial_clock_in,
  input wire logic [3:0] host_pin,
  input wire logic [3:0] host_oe,
  input wire logic dev_sdo_oe,
  input wire logic [3:0] line,
  input wire logic contention
);
  logic [15:0] hv_cnt_r;
  logic [3:0] low_cnt_r;
  logic [3:0] rise_cnt_r;
  logic sci_q_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // cycles since high voltage came up, saturating
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hv_cnt_r <= 16'h0000;
    end else if (!hv_rst) begin
      hv_cnt_r <= 16'h0000;
    end else if (hv_cnt_r != 16'hFFFF) begin
      hv_cnt_r <= hv_cnt_r + 16'h0001;
    end
  end

  // frame tracking: low gaps between bits never exceed 4 cycles
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sci_q_r <= 1'b0;
      low_cnt_r <= 4'h0;
      rise_cnt_r <= 4'h0;
    end else begin
      sci_q_r <= serial_clock_in;
      low_cnt_r <= serial_clock_in ? 4'h0 : ((low_cnt_r == 4'hF) ? low_cnt_r : low_cnt_r + 4'h1);
      if (serial_clock_in && !sci_q_r) begin
        rise_cnt_r <= rise_cnt_r + 4'h1;
      end else if (low_cnt_r == 4'h7) begin
        rise_cnt_r <= 4'h0;
      end
    end
  end

  property p_sci_pulse;
    $rose(serial_clock_in) |-> serial_clock_in [*4] ##1 !serial_clock_in;
  endproperty
  a_sci_pulse: assert property (p_sci_pulse)
    else $error("serial clock high time wrong");

  property p_entry_pins;
    $rose(hv_rst) |-> vcc_on && host_oe == OE_ENTRY && host_pin == ENTRY_PATTERN;
  endproperty
  a_entry_pins: assert property (p_entry_pins)
    else $error("straps not 0000 at high voltage");

  property p_strap_hold;
    hv_rst && hv_cnt_r < 16'(STRAP_HOLD_CYC) |-> host_oe == OE_ENTRY && line == ENTRY_PATTERN;
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("straps changed too early");

  property p_release;
    hv_cnt_r == 16'(STRAP_HOLD_CYC + 20) |-> host_oe == OE_RUN;
  endproperty
  a_release: assert property (p_release)
    else $error("data out strap not released");

  // a short overlap while the device latches is tolerated
  property p_no_contention;
    hv_cnt_r > 16'(STRAP_HOLD_CYC + 20) |-> !contention;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("both ends drive data out");

  property p_first_frame;
    $rose(serial_clock_in) |-> hv_rst && hv_cnt_r >= 16'(STRAP_HOLD_CYC + ENTRY_WAIT);
  endproperty
  a_first_frame: assert property (p_first_frame)
    else $error("frame sent before entry wait");

  property p_data_stable;
    serial_clock_in && $past(serial_clock_in) |-> $stable(line[3:2]);
  endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("data moved while clock high");

  property p_frame_len;
    low_cnt_r == 4'h6 |-> rise_cnt_r == 4'h0 || rise_cnt_r == 4'hB;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame not eleven clocks");

  property p_frame_bits;
    $rose(serial_clock_in) && (rise_cnt_r == 4'h0 || rise_cnt_r > 4'h8) |-> line[3:2] == 2'b00;
  endproperty
  a_frame_bits: assert property (p_frame_bits)
    else $error("framing bit not zero");

  property p_exit;
    $fell(hv_rst) |-> ##[1:8] !dev_sdo_oe;
  endproperty
  a_exit: assert property (p_exit)
    else $error("device still drives after exit");

  c_frame: cover property (low_cnt_r == 4'h6 && rise_cnt_r == 4'hB);
  c_sdo_on: cover property ($rose(dev_sdo_oe));
  c_exit: cover property ($fell(hv_rst));
endmodule : hvsp_chk

/* File: hv_serial_programming_port_test.sv */
// bench: host and device ends joined, plus a device fed bad straps
`timescale 1ns/1ps
module hv_serial_programming_port_test;
  import hvsp_pkg::*;
  localparam int EW = 20;
  localparam logic [7:0] I_LATCH_END = 8'h7C;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic enter_i = 1'b0;
  logic exit_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [7:0] cmd_instr_i = 8'h00;
  logic [7:0] cmd_data_i = 8'h00;
  logic cmd_wait_i = 1'b0;
  logic fuse = 1'b0;
  logic cmd_ready_o, rsp_valid_o, prog_mode_o, busy_o, bad_mode, saw_busy;
  logic [7:0] rsp_data_o;
  logic [7:0] got;
  logic [1:0] lock_bits_o;
  logic [15:0] wd [2] = '{16'h12C3, 16'h7E81};
  int mismatches = 0;
  int num_checks = 0;

  hvsp_if link_if();
  hvsp_if bad_if();
  always #50 clk_i = ~clk_i;
  always @(negedge clk_i) if (busy_o === 1'b1) saw_busy = 1'b1;

  hvsp_host #(.ENTRY_WAIT(EW)) hvsp_host_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .pins(link_if.host), .enter_i(enter_i), .exit_i(exit_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_instr_i(cmd_instr_i), .cmd_data_i(cmd_data_i),
    .cmd_wait_i(cmd_wait_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o));
  hvsp_dev hvsp_dev_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .pins(link_if.dev),
    .preserve_eeprom_fuse_i(fuse), .prog_mode_o(prog_mode_o), .busy_o(busy_o),
    .lock_bits_o(lock_bits_o));
  hvsp_dev hvsp_dev_strap_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .pins(bad_if.dev),
    .preserve_eeprom_fuse_i(fuse), .prog_mode_o(bad_mode), .busy_o(), .lock_bits_o());
  hvsp_chk #(.ENTRY_WAIT(EW)) hvsp_chk_i (.clk_i(clk_i), .rst_i(rst_i),
    .hv_rst(link_if.hv_rst), .vcc_on(link_if.vcc_on), .serial_clock_in(link_if.serial_clock_in),
    .host_pin(link_if.host_pin), .host_oe(link_if.host_oe), .dev_sdo_oe(link_if.dev_sdo_oe),
    .line(link_if.line), .contention(link_if.contention));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // one frame: hold the request until taken, then wait for its answer
  task automatic xfer(input logic [7:0] ins, input logic [7:0] dat = 8'h00, input logic wt = 1'b0);
    logic s;
    int n = 0;
    @(posedge clk_i);
    #1;
    cmd_valid_i = 1'b1;
    cmd_instr_i = ins;
    cmd_data_i = dat;
    cmd_wait_i = wt;
    do begin
      @(negedge clk_i);
      s = cmd_ready_o;
      n++;
      @(posedge clk_i);
    end while (s !== 1'b1 && n < 3000);
    #1;
    cmd_valid_i = 1'b0;
    do begin
      @(negedge clk_i);
      s = rsp_valid_o;
      got = rsp_data_o;
      n++;
      @(posedge clk_i);
    end while (s !== 1'b1 && n < 6000);
    if (s !== 1'b1) check("frame answer", 16'h0000, 16'h0001);
  endtask : xfer

  task automatic erase();
    saw_busy = 1'b0;
    xfer(I_LOAD_CMD, C_ERASE);
    xfer(I_PROG_A);
    xfer(I_PROG_B, 8'h00, 1'b1);
    @(negedge clk_i);
    check("erase ran", 16'(saw_busy), 16'h0001);
    check("ready after erase", 16'(busy_o), 16'h0000);
    check("lock after erase", 16'(lock_bits_o), 16'(LOCK_CLEAR));
    xfer(I_LOAD_CMD, C_NOP);
  endtask : erase

  task automatic rd_flash(input logic ld, input logic [7:0] alo, input logic [15:0] exp);
    if (ld) begin
      xfer(I_LOAD_CMD, C_RD_FLASH);
      xfer(I_ADDR_HI, 8'h01);
    end
    xfer(I_ADDR_LO, alo);
    xfer(I_RD_LO);
    xfer(I_PROG_B);
    check("flash low", {8'h00, got}, {8'h00, exp[7:0]});
    xfer(I_RD_HI);
    xfer(I_LATCH_END);
    check("flash high", {8'h00, got}, {8'h00, exp[15:8]});
  endtask : rd_flash

  task automatic rd_ee(input logic ld, input logic [7:0] alo, input logic [7:0] exp);
    if (ld) begin
      xfer(I_LOAD_CMD, C_RD_EE);
      xfer(I_ADDR_HI, 8'h01);
    end
    xfer(I_ADDR_LO, alo);
    xfer(I_RD_LO);
    xfer(I_PROG_B);
    check("eeprom byte", {8'h00, got}, {8'h00, exp});
  endtask : rd_ee

  initial begin
    repeat (40000) @(posedge clk_i);
    mismatches++;
    test_done();
  end

  initial begin
    bad_if.vcc_on = 1'b0;
    bad_if.hv_rst = 1'b0;
    bad_if.serial_clock_in = 1'b0;
    bad_if.host_pin = 4'h4;
    bad_if.host_oe = 4'hF;
    repeat (4) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    @(posedge clk_i);
    #1;
    enter_i = 1'b1;
    bad_if.vcc_on = 1'b1;
    @(posedge clk_i);
    #1;
    enter_i = 1'b0;
    bad_if.hv_rst = 1'b1;
    for (int i = 0; i < 1000 && link_if.hv_rst !== 1'b1; i++) @(negedge clk_i);
    repeat (STRAP_HOLD_CYC) @(negedge clk_i);
    check("mode latched", 16'(prog_mode_o), 16'h0001);
    check("bad straps mode", 16'(bad_mode), 16'h0000);
    check("bad straps drive", 16'(bad_if.dev_sdo_oe), 16'h0000);
    $display("test entry done");
    erase();
    rd_flash(1'b1, 8'h03, ERASED_WORD);
    rd_ee(1'b1, 8'h05, ERASED_BYTE);
    $display("test erased read done");
    // two words, one page write: buffer must hold both
    xfer(I_LOAD_CMD, C_WR_FLASH);
    for (int i = 0; i < 2; i++) begin
      xfer(I_ADDR_LO, 8'h03 + 8'(i));
      xfer(I_DATA_LO, wd[i][7:0]);
      xfer(I_DATA_HI, wd[i][15:8]);
      xfer(I_LATCH_F);
      xfer(I_LATCH_END);
    end
    xfer(I_ADDR_HI, 8'h01);
    xfer(I_PROG_A);
    xfer(I_PROG_B, 8'h00, 1'b1);
    xfer(I_LOAD_CMD, C_NOP);
    xfer(I_LOAD_CMD, C_WR_EE);
    xfer(I_ADDR_LO, 8'h05);
    xfer(I_DATA_LO, 8'h5A);
    xfer(I_LATCH_E);
    xfer(I_PROG_B);
    xfer(I_PROG_A);
    xfer(I_PROG_B, 8'h00, 1'b1);
    xfer(I_LOAD_CMD, C_NOP);
    $display("test program done");
    xfer(I_LOAD_CMD, C_RD_FLASH);
    rd_flash(1'b0, 8'h03, wd[0]);
    rd_flash(1'b0, 8'h04, wd[1]);
    rd_ee(1'b1, 8'h05, 8'h5A);
    rd_ee(1'b0, 8'h06, ERASED_BYTE);
    $display("test readback done");
    #1;
    fuse = 1'b1;
    erase();
    rd_ee(1'b1, 8'h05, 8'h5A);
    rd_flash(1'b1, 8'h03, ERASED_WORD);
    #1;
    fuse = 1'b0;
    erase();
    rd_ee(1'b1, 8'h05, ERASED_BYTE);
    $display("test erase modes done");
    #1;
    exit_i = 1'b1;
    repeat (20) @(negedge clk_i);
    check("mode left", 16'(prog_mode_o), 16'h0000);
    check("data out released", 16'(link_if.dev_sdo_oe), 16'h0000);
    $display("test exit done");
    test_done();
  end
endmodule : hv_serial_programming_port_test
